// *** src/evt_trap_defines.vh ***
// Register offsets, field layouts, reset values and timing counts
`ifndef EVT_TRAP_DEFINES_VH
`define EVT_TRAP_DEFINES_VH
// Register byte addresses
`define ADDR_EDGE_SEL    16'hf1c0
`define ADDR_EC_CFG      16'hf1c4
`define ADDR_REQ_FLAGS   16'hf1c8
`define ADDR_TRAP_FLAGS  16'hf1cc
`define ADDR_STATUS      16'hf1d0
// Reset values
`define RST_EDGE_SEL     16'h0000
`define RST_EC_CFG       16'h0000
`define RST_TRAP_FLAGS   16'h0000
// Edge select field codes
`define EDGE_STD         2'h0
`define EDGE_RISE        2'h1
`define EDGE_FALL        2'h2
`define EDGE_ANY         2'h3
// Trap flag bit positions
`define TF_NMI           15
`define TF_STKOF         14
`define TF_STKUF         13
`define TF_DEBUG         12
`define TF_UNDOPC        7
`define TF_PRTFLT        3
`define TF_ILLOPA        2
`define TF_ILLINA        1
`define TF_ILLBUS        0
`define TF_MASK          16'hf08f
// Trap vectors (word addresses in the low vector range)
`define VEC_NMI          9'h008
`define VEC_STKOF        9'h010
`define VEC_STKUF        9'h018
`define VEC_DEBUG        9'h020
`define VEC_CLASS_B      9'h028
`define HW_TRAP_LEVEL    4'hf
// Trap classes, higher value wins
`define TCLS_NONE        2'h0
`define TCLS_B           2'h1
`define TCLS_A           2'h2
`define TCLS_DEBUG       2'h3
// Timing in states (one state = one pclk = two clock phases)
`define STD_SAMPLE_STATES  8
`define ARB_STATES         4
`define XFER_MIN_STATES    4'h2
`define EXTRA_HOLD         4'h1
`define EXTRA_CODE_RD      4'h2
`define EXTRA_PSW_DEP      4'h2
`define EXTRA_MAX          4'h9
`define EXTRA_EXTENDED     4'h2
`endif

// *** src/evt_trap_entry.v ***
// Event-channel injection, fast interrupt lines and trap entry logic
`timescale 1ns/1ns
`include "evt_trap_defines.vh"

module evt_trap_entry (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [15:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // External interrupt pins and sleep
    input  wire [7:0]  fast_line,
    input  wire        sleep_mode,
    output wire        sleep_wake,
    // Pipeline status
    input  wire        instr_last_state,
    input  wire [1:0]  hold_cnt,
    input  wire        code_operand_rd,
    input  wire        psw_rd_after_flags,
    input  wire        ext_conflict,
    input  wire        ecc_read,
    input  wire        xfer_bus_busy,
    input  wire        segmented,
    input  wire        return_from_interrupt,
    // Trap conditions
    input  wire        nmi_evt,
    input  wire        stk_over_evt,
    input  wire        stk_under_evt,
    input  wire        debug_evt,
    input  wire [4:0]  class_b_evt,
    input  wire        sw_trap_req,
    input  wire [6:0]  sw_trap_num,
    // Event channel and interrupt outputs
    output reg         xfer_inject,
    output reg  [2:0]  xfer_chan,
    output reg         xfer_done,
    output reg         instr_stall,
    output reg  [7:0]  irq_req,
    output wire        irq_block,
    // Trap entry outputs
    output reg         trap_take,
    output reg  [8:0]  trap_vector,
    output reg         trap_set_level,
    output reg  [3:0]  trap_level,
    output reg         trap_cs_zero,
    output reg         trap_cancel
);

    // ************************************************************
    // Declarations
    // ************************************************************
    localparam ST_IDLE  = 3'h0;
    localparam ST_DELAY = 3'h1;
    localparam ST_PRIO  = 3'h2;
    localparam ST_INJ   = 3'h3;
    localparam ST_XFER  = 3'h4;

    reg  [15:0] edge_sel_ff;
    reg  [15:0] ec_cfg_ff;
    reg  [7:0]  req_ff;
    reg  [15:0] tfr_ff;
    reg  [7:0]  sync1_ff;
    reg  [7:0]  sync2_ff;
    reg  [7:0]  prev_ff;
    reg  [7:0]  std_prev_ff;
    reg  [2:0]  div_ff;
    reg  [2:0]  state_ff;
    reg  [3:0]  cnt_ff;
    reg  [2:0]  chan_ff;
    reg  [1:0]  cls_ff;
    reg  [1:0]  saved_cls_ff;
    reg  [7:0]  nxt_req;
    reg  [15:0] nxt_tfr;
    reg  [7:0]  det;
    reg  [4:0]  extra;
    reg  [2:0]  win;
    reg         win_ok;
    integer     i;

    wire        wr_en = psel & penable & pwrite;
    wire        std_tick = (div_ff == 3'h7);
    wire        arb_tick = (div_ff[1:0] == 2'h3);
    wire [7:0]  chan_en = ec_cfg_ff[7:0];
    wire [7:0]  chan_ext = ec_cfg_ff[15:8];
    wire [7:0]  ec_pend = req_ff & chan_en;
    wire        acc_hit = (paddr == `ADDR_EDGE_SEL) | (paddr == `ADDR_EC_CFG) |
                          (paddr == `ADDR_REQ_FLAGS) | (paddr == `ADDR_TRAP_FLAGS) |
                          (paddr == `ADDR_STATUS);

    // Returns the mode field of one line
    function [1:0] mode_of;
        input [15:0] sel;
        input [2:0]  idx;
        begin
            mode_of = sel[{idx, 1'b0} +: 2];
        end
    endfunction

    // Edge match for a given mode, old and new level
    function edge_hit;
        input [1:0] mode;
        input       old_lvl;
        input       new_lvl;
        begin
            case (mode)
                `EDGE_RISE: edge_hit = ~old_lvl & new_lvl;
                `EDGE_FALL: edge_hit = old_lvl & ~new_lvl;
                `EDGE_ANY:  edge_hit = old_lvl ^ new_lvl;
                default:    edge_hit = 1'b0;
            endcase
        end
    endfunction

    // Pending trap class from the flag register
    function [1:0] trap_class;
        input [15:0] f;
        begin
            if (f[`TF_DEBUG])
                trap_class = `TCLS_DEBUG;
            else if (f[`TF_NMI] | f[`TF_STKOF] | f[`TF_STKUF])
                trap_class = `TCLS_A;
            else if (|(f & 16'h008f))
                trap_class = `TCLS_B;
            else
                trap_class = `TCLS_NONE;
        end
    endfunction

    wire [1:0] pend_cls = trap_class(tfr_ff);
    wire       hw_trap_go = (pend_cls > cls_ff);
    // Traps bypass every interrupt request
    assign irq_block = hw_trap_go | sw_trap_req;

    // ************************************************************
    // APB slave
    // ************************************************************
    // Zero wait state; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~acc_hit;

    // Read data registered at the setup cycle so it is stable in access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            case (paddr)
                `ADDR_EDGE_SEL:   prdata <= {16'h0000, edge_sel_ff};
                `ADDR_EC_CFG:     prdata <= {16'h0000, ec_cfg_ff};
                `ADDR_REQ_FLAGS:  prdata <= {24'h000000, req_ff};
                `ADDR_TRAP_FLAGS: prdata <= {16'h0000, tfr_ff};
                `ADDR_STATUS:     prdata <= {22'h000000, cls_ff, chan_ff, state_ff,
                                             instr_stall, xfer_inject};
                default:          prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Configuration registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_sel_ff <= `RST_EDGE_SEL;
            ec_cfg_ff   <= `RST_EC_CFG;
        end else if (wr_en) begin
            if (paddr == `ADDR_EDGE_SEL)
                edge_sel_ff <= pwdata[15:0];
            if (paddr == `ADDR_EC_CFG)
                ec_cfg_ff <= pwdata[15:0];
        end
    end

    // ************************************************************
    // Line sampling and request detection
    // ************************************************************
    // Two-stage synchroniser, then a third stage for edge history
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff    <= 8'h00;
            sync2_ff    <= 8'h00;
            prev_ff     <= 8'h00;
            std_prev_ff <= 8'h00;
            div_ff      <= 3'h0;
        end else begin
            sync1_ff <= fast_line;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
            div_ff   <= div_ff + 3'h1;
            if (std_tick)
                std_prev_ff <= sync2_ff;
        end
    end

    // Fast lines every state; standard lines only on the slow tick
    always @* begin
        det = 8'h00;
        for (i = 0; i < 8; i = i + 1) begin
            if (mode_of(edge_sel_ff, i[2:0]) == `EDGE_STD)
                det[i] = std_tick & ~std_prev_ff[i] & sync2_ff[i];
            else
                det[i] = edge_hit(mode_of(edge_sel_ff, i[2:0]), prev_ff[i],
                                  sync2_ff[i]);
        end
    end

    // Clockless wake path: raw pins against last sampled level.
    // Only usable as a wake source, it is not glitch filtered.
    reg [7:0] wake_vec;
    always @* begin
        wake_vec = 8'h00;
        for (i = 0; i < 8; i = i + 1)
            wake_vec[i] = edge_hit(mode_of(edge_sel_ff, i[2:0]), prev_ff[i],
                                   fast_line[i]);
    end
    assign sleep_wake = sleep_mode & (|wake_vec);

    // Request flags: set wins over software and injection clear
    always @* begin
        nxt_req = req_ff;
        if (wr_en & (paddr == `ADDR_REQ_FLAGS))
            nxt_req = nxt_req & ~pwdata[7:0];
        if (state_ff == ST_INJ)
            nxt_req[chan_ff] = 1'b0;
        nxt_req = nxt_req | det;
    end

    // Standard requests forwarded on the arbitration tick only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_ff  <= 8'h00;
            irq_req <= 8'h00;
        end else begin
            req_ff <= nxt_req;
            if (arb_tick)
                irq_req <= req_ff & ~chan_en;
        end
    end

    // ************************************************************
    // Event channel sequencer
    // ************************************************************
    // Winner is the highest numbered pending channel
    always @* begin
        win    = 3'h0;
        win_ok = 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            if (ec_pend[i]) begin
                win    = i[2:0];
                win_ok = 1'b1;
            end
        end
    end

    // Extra states charged from the pipeline condition at detection
    always @* begin
        extra = {3'h0, hold_cnt} * {1'b0, `EXTRA_HOLD};
        if (code_operand_rd)
            extra = extra + {1'b0, `EXTRA_CODE_RD};
        if (psw_rd_after_flags)
            extra = extra + {1'b0, `EXTRA_PSW_DEP};
        if (extra > {1'b0, `EXTRA_MAX})
            extra = {1'b0, `EXTRA_MAX};
        if (!instr_last_state)
            extra = extra + 5'h01;
        if (chan_ext[win])
            extra = extra + {1'b0, `EXTRA_EXTENDED};
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff    <= ST_IDLE;
            cnt_ff      <= 4'h0;
            chan_ff     <= 3'h0;
            xfer_inject <= 1'b0;
            xfer_done   <= 1'b0;
            xfer_chan   <= 3'h0;
            instr_stall <= 1'b0;
        end else begin
            xfer_inject <= 1'b0;
            xfer_done   <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (win_ok & ~irq_block) begin
                        chan_ff <= win;
                        if (extra == 5'h00) begin
                            state_ff <= ST_PRIO;
                        end else begin
                            cnt_ff   <= extra[3:0];
                            state_ff <= ST_DELAY;
                        end
                    end
                end
                ST_DELAY: begin
                    // Only a real bus conflict freezes the count
                    if (!ext_conflict) begin
                        cnt_ff <= cnt_ff - 4'h1;
                        if (cnt_ff == 4'h1)
                            state_ff <= ST_PRIO;
                    end
                end
                ST_PRIO: begin
                    if (ecc_read)
                        state_ff <= ST_PRIO;
                    else if (!ec_pend[chan_ff])
                        state_ff <= ST_IDLE;
                    else
                        state_ff <= ST_INJ;
                end
                ST_INJ: begin
                    xfer_inject <= 1'b1;
                    xfer_chan   <= chan_ff;
                    instr_stall <= 1'b1;
                    cnt_ff      <= `XFER_MIN_STATES;
                    state_ff    <= ST_XFER;
                end
                ST_XFER: begin
                    // Minimum stall plus any external operand traffic
                    if (cnt_ff != 4'h1)
                        cnt_ff <= cnt_ff - 4'h1;
                    else if (!xfer_bus_busy) begin
                        instr_stall <= 1'b0;
                        xfer_done   <= 1'b1;
                        state_ff    <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Trap flag register and trap entry
    // ************************************************************
    // Software may write any flag; a hardware event in the same cycle wins
    always @* begin
        nxt_tfr = tfr_ff;
        if (wr_en & (paddr == `ADDR_TRAP_FLAGS))
            nxt_tfr = pwdata[15:0] & `TF_MASK;
        nxt_tfr[`TF_NMI]    = nxt_tfr[`TF_NMI] | nmi_evt;
        nxt_tfr[`TF_STKOF]  = nxt_tfr[`TF_STKOF] | stk_over_evt;
        nxt_tfr[`TF_STKUF]  = nxt_tfr[`TF_STKUF] | stk_under_evt;
        nxt_tfr[`TF_DEBUG]  = nxt_tfr[`TF_DEBUG] | debug_evt;
        nxt_tfr[`TF_UNDOPC] = nxt_tfr[`TF_UNDOPC] | class_b_evt[4];
        nxt_tfr[`TF_PRTFLT] = nxt_tfr[`TF_PRTFLT] | class_b_evt[3];
        nxt_tfr[`TF_ILLOPA] = nxt_tfr[`TF_ILLOPA] | class_b_evt[2];
        nxt_tfr[`TF_ILLINA] = nxt_tfr[`TF_ILLINA] | class_b_evt[1];
        nxt_tfr[`TF_ILLBUS] = nxt_tfr[`TF_ILLBUS] | class_b_evt[0];
    end

    // Flags stay set until the handler clears them, so the entry
    // below fires once per class change, not once per flag.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tfr_ff         <= `RST_TRAP_FLAGS;
            cls_ff         <= `TCLS_NONE;
            saved_cls_ff   <= `TCLS_NONE;
            trap_take      <= 1'b0;
            trap_vector    <= 9'h000;
            trap_set_level <= 1'b0;
            trap_level     <= 4'h0;
            trap_cs_zero   <= 1'b0;
            trap_cancel    <= 1'b0;
        end else begin
            tfr_ff    <= nxt_tfr;
            trap_take <= 1'b0;
            if (hw_trap_go) begin
                trap_take      <= 1'b1;
                saved_cls_ff   <= cls_ff;
                cls_ff         <= pend_cls;
                trap_set_level <= 1'b1;
                trap_level     <= `HW_TRAP_LEVEL;
                trap_cs_zero   <= segmented;
                trap_cancel    <= 1'b0;
                if (pend_cls == `TCLS_DEBUG)
                    trap_vector <= `VEC_DEBUG;
                else if (tfr_ff[`TF_NMI])
                    trap_vector <= `VEC_NMI;
                else if (tfr_ff[`TF_STKOF])
                    trap_vector <= `VEC_STKOF;
                else if (tfr_ff[`TF_STKUF])
                    trap_vector <= `VEC_STKUF;
                else begin
                    trap_vector <= `VEC_CLASS_B;
                    // Decode faults abort the instruction, access faults finish it
                    trap_cancel <= tfr_ff[`TF_UNDOPC] | tfr_ff[`TF_PRTFLT];
                end
            end else if (sw_trap_req) begin
                trap_take      <= 1'b1;
                trap_vector    <= {sw_trap_num, 2'b00};
                trap_set_level <= 1'b0;
                trap_cs_zero   <= segmented;
                trap_cancel    <= 1'b0;
            end else if (return_from_interrupt) begin
                cls_ff       <= saved_cls_ff;
                saved_cls_ff <= `TCLS_NONE;
            end
        end
    end

endmodule // evt_trap_entry

// *** verification/evt_trap_entry_assertions.sv ***
// Concurrent checks on the event-channel, fast-line and trap entry ports
`timescale 1ns/1ns
`include "evt_trap_defines.vh"
module evt_trap_entry_assertions (
    // Clock and reset
    input wire       pclk,
    input wire       presetn,
    // Register bus
    input wire       psel,
    input wire       penable,
    input wire [15:0] paddr,
    input wire       pready,
    input wire       pslverr,
    // Lines and pipeline
    input wire       sleep_mode,
    input wire       sleep_wake,
    input wire       segmented,
    input wire       sw_trap_req,
    input wire [6:0] sw_trap_num,
    // Outputs under watch
    input wire       xfer_inject,
    input wire       xfer_done,
    input wire       instr_stall,
    input wire       irq_block,
    input wire       trap_take,
    input wire [8:0] trap_vector,
    input wire       trap_set_level,
    input wire [3:0] trap_level,
    input wire       trap_cs_zero,
    input wire       trap_cancel
);
// ****************
// Properties
// ****************
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
// Decoded register window, refused outside it
wire mapped = paddr inside {`ADDR_EDGE_SEL, `ADDR_EC_CFG, `ADDR_REQ_FLAGS,
                            `ADDR_TRAP_FLAGS, `ADDR_STATUS};
a_ready_high: assert property (psel |-> pready)
    else $error("pready low during a transfer");
a_err_unmapped: assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr does not match the address decode");
a_stall_two: assert property ($rose(xfer_inject) |-> instr_stall ##1 instr_stall)
    else $error("stall shorter than two states");
a_done_bound: assert property (xfer_inject |-> ##[2:40] xfer_done)
    else $error("transfer never completed");
a_done_ends: assert property (xfer_done |-> !instr_stall)
    else $error("stall still high at completion");
a_inject_pulse: assert property (xfer_inject |=> !xfer_inject)
    else $error("inject longer than one state");
a_sw_entry: assert property (sw_trap_req |=> trap_take && !trap_set_level
    && trap_vector == {$past(sw_trap_num), 2'h0})
    else $error("software trap entry wrong");
a_hw_entry: assert property (trap_take && trap_set_level |->
    trap_level == `HW_TRAP_LEVEL && trap_vector inside {`VEC_NMI, `VEC_STKOF,
    `VEC_STKUF, `VEC_DEBUG, `VEC_CLASS_B})
    else $error("hardware trap entry wrong");
a_cancel_classb: assert property (trap_take && trap_cancel |-> trap_vector == `VEC_CLASS_B)
    else $error("cancel outside class B");
a_seg_zero: assert property (trap_take |-> trap_cs_zero == segmented)
    else $error("segment clear does not follow segmentation");
a_sleep_gate: assert property (!sleep_mode |-> !sleep_wake)
    else $error("wake outside sleep");
a_block_sw: assert property (sw_trap_req |-> irq_block)
    else $error("interrupts not blocked by trap");
a_block_hw: assert property (trap_take && trap_set_level |-> $past(irq_block))
    else $error("hardware trap entered without blocking");
// Main scenarios reached
c_inject: cover property (xfer_inject);
c_hw_trap: cover property (trap_take && trap_set_level);
c_sw_trap: cover property (trap_take && !trap_set_level);
c_refused: cover property (psel && penable && pslverr);
endmodule // evt_trap_entry_assertions

// *** verification/pipe_model.sv ***
// Pipeline-side partner: instruction state marker and handler return
`timescale 1ns/1ns
module pipe_model (
    // Clock and reset
    input wire       pclk,
    input wire       presetn,
    // Mode from bench, entry from design
    input wire [1:0] last_mode,
    input wire       trap_take,
    input wire       trap_set_level,
    // Pipeline outputs
    output reg       instr_last_state,
    output reg       return_from_interrupt
);
reg [3:0] ret_cnt_ff;
// Mode 1 pins last state high, 2 and 3 low, 0 two-state cycles;
// handlers return late so software can clear flags first
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        instr_last_state <= 1'h0;
        return_from_interrupt <= 1'h0;
        ret_cnt_ff <= 4'h0;
    end else begin
        instr_last_state <= (last_mode == 2'h1) | ((last_mode == 2'h0) & ~instr_last_state);
        return_from_interrupt <= (ret_cnt_ff == 4'h1);
        if (trap_take && trap_set_level) ret_cnt_ff <= 4'hc;
        else if (ret_cnt_ff != 4'h0) ret_cnt_ff <= ret_cnt_ff - 4'h1;
    end
end
endmodule // pipe_model

// *** verification/evt_trap_entry_tb_top.sv ***
// Self-checking bench for the event-channel, fast-line and trap entry block
`timescale 1ns/1ns
`include "evt_trap_defines.vh"
module evt_trap_entry_tb_top;
// ****************
// Signals and tables
// ****************
reg        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
reg [15:0] paddr = 16'h0;
reg [31:0] pwdata = 32'h0, q;
reg [7:0]  fast_line = 8'h0;
reg        sleep_mode = 1'h0, code_operand_rd = 1'h0, psw_rd_after_flags = 1'h0;
reg        ext_conflict = 1'h0, ecc_read = 1'h0, xfer_bus_busy = 1'h0, segmented = 1'h0;
reg        nmi_evt = 1'h0, stk_over_evt = 1'h0, stk_under_evt = 1'h0, debug_evt = 1'h0;
reg        sw_trap_req = 1'h0, se;
reg [1:0]  hold_cnt = 2'h0, last_mode = 2'h1;
reg [4:0]  class_b_evt = 5'h0;
reg [6:0]  sw_trap_num = 7'h0;
wire [31:0] prdata;
wire        pready, pslverr, sleep_wake, instr_last_state, return_from_interrupt, xfer_inject, xfer_done;
wire        instr_stall, irq_block, trap_take, trap_set_level, trap_cs_zero, trap_cancel;
wire [2:0]  xfer_chan;
wire [7:0]  irq_req;
wire [8:0]  trap_vector;
wire [3:0]  trap_level;
wire [2:0]  evs = {trap_take, xfer_done, xfer_inject};
int err_count = 0, check_count = 0, lat, base, i, m;
typedef struct {logic [1:0] hold; logic code, processor_status_word, ext; logic [1:0] last; int extra;} row_t;
typedef struct {logic [8:0] ev, vec; logic cnc; logic [15:0] fl;} trap_t;
// Qualifiers beside the extra states they should cost
row_t rows [8] = '{'{0,0,0,0,1,0}, '{1,0,0,0,1,1}, '{2,0,0,0,1,2}, '{0,1,0,0,1,2},
                   '{0,0,1,0,1,2}, '{2,1,1,0,1,6}, '{0,0,0,1,1,2}, '{0,0,0,0,2,1}};
// Events {nmi, over, under, debug, class B} beside vector, cancel and flags
trap_t traps [7] = '{'{9'h100, 9'h008, 0, 16'h8000}, '{9'h0c0, 9'h010, 0, 16'h6000},
    '{9'h040, 9'h018, 0, 16'h2000}, '{9'h020, 9'h020, 0, 16'h1000},
    '{9'h010, 9'h028, 1, 16'h0080}, '{9'h001, 9'h028, 0, 16'h0001},
    '{9'h120, 9'h020, 0, 16'h9000}};
always #20 pclk = ~pclk;
evt_trap_entry evt_trap_entry_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .fast_line, .sleep_mode, .sleep_wake,
    .instr_last_state, .hold_cnt, .code_operand_rd, .psw_rd_after_flags, .ext_conflict,
    .ecc_read, .xfer_bus_busy, .segmented, .return_from_interrupt, .nmi_evt, .stk_over_evt, .stk_under_evt,
    .debug_evt, .class_b_evt, .sw_trap_req, .sw_trap_num, .xfer_inject, .xfer_chan,
    .xfer_done, .instr_stall, .irq_req, .irq_block, .trap_take, .trap_vector,
    .trap_set_level, .trap_level, .trap_cs_zero, .trap_cancel);
pipe_model pipe_model_inst (.pclk, .presetn, .last_mode, .trap_take, .trap_set_level,
    .instr_last_state, .return_from_interrupt);
// ****************
// Tasks
// ****************
task chk(input [31:0] g, input [31:0] e);
    check_count++;
    if (g !== e) begin
        err_count++;
        $display("BAD %0t got %h exp %h", $time, g, e);
    end
endtask
task give_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask
// One APB transfer; holds the request until pready is seen high
task apb(input w, input [15:0] a, input [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
        @(posedge pclk);
        n++;
    end while (pready !== 1'h1 && n < 20);
    q = prdata;
    se = pslverr;
    if (n >= 20) begin
        err_count++;
        give_verdict;
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
endtask
// Edges until inject (0), done (1) or trap entry (2); bounded
task wait_for(input int k);
    lat = 0;
    do begin
        @(posedge pclk);
        lat++;
    end while (evs[k] !== 1'h1 && lat < 60);
    if (lat >= 60) begin
        err_count++;
        give_verdict;
    end
endtask
// ****************
// Sequence
// ****************
initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(0, `ADDR_EDGE_SEL, 32'h0);
    chk(q, 32'h0);
    apb(1, `ADDR_EDGE_SEL, 32'hffffffff);
    apb(0, `ADDR_EDGE_SEL, 32'h0);
    chk(q, 32'h0000ffff);
    apb(0, `ADDR_TRAP_FLAGS, 32'h0);
    chk(q, 32'h0);
    apb(0, 16'hf1e0, 32'h0);
    chk({se, q[30:0]}, 32'h80000000);
    apb(1, `ADDR_EDGE_SEL, 32'h1);
    // Response rows on line 0 as a channel
    for (i = 0; i < 8; i++) begin
        hold_cnt <= rows[i].hold;
        code_operand_rd <= rows[i].code;
        psw_rd_after_flags <= rows[i].processor_status_word;
        last_mode <= rows[i].last;
        apb(1, `ADDR_EC_CFG, {23'h0, rows[i].ext, 8'h01});
        fast_line[0] <= 1'h1;
        wait_for(0);
        if (i == 0) base = lat;
        chk(lat, base + rows[i].extra);
        chk(xfer_chan, 32'h0);
        wait_for(1);
        chk(lat, 32'h2);
        apb(0, `ADDR_REQ_FLAGS, 32'h0);
        chk(q[0], 32'h0);
        fast_line[0] <= 1'h0;
        repeat (8) @(posedge pclk);
    end
    chk(base >= 7 && base <= 9, 32'h1);
    // Busy bus keeps the stall beyond two states
    xfer_bus_busy <= 1'h1;
    fast_line[0] <= 1'h1;
    wait_for(0);
    repeat (3) @(posedge pclk);
    chk(instr_stall, 32'h1);
    xfer_bus_busy <= 1'h0;
    wait_for(1);
    fast_line[0] <= 1'h0;
    repeat (8) @(posedge pclk);
    // Bus conflict and control reads push the start out
    {ext_conflict, ecc_read, fast_line[0]} <= 3'h7;
    repeat (6) @(posedge pclk);
    ext_conflict <= 1'h0;
    repeat (2) @(posedge pclk);
    ecc_read <= 1'h0;
    wait_for(0);
    chk(lat + 8, base + 4);
    wait_for(1);
    fast_line[0] <= 1'h0;
    apb(1, `ADDR_EC_CFG, 32'h0);
    // Every edge code on line 3
    for (m = 0; m < 4; m++) begin
        apb(1, `ADDR_EDGE_SEL, m << 6);
        fast_line[3] <= 1'h1;
        repeat (16) @(posedge pclk);
        chk(irq_req[3], m != 2);
        apb(1, `ADDR_REQ_FLAGS, 32'h8);
        fast_line[3] <= 1'h0;
        repeat (16) @(posedge pclk);
        apb(0, `ADDR_REQ_FLAGS, 32'h0);
        chk(q[3], m[1]);
        apb(1, `ADDR_REQ_FLAGS, 32'h8);
    end
    // Sleep detection on line 2, flag kept for the software traps
    apb(1, `ADDR_EDGE_SEL, 32'h10);
    sleep_mode <= 1'h1;
    fast_line[2] <= 1'h1;
    @(posedge pclk);
    chk(sleep_wake, 32'h1);
    sleep_mode <= 1'h0;
    repeat (16) @(posedge pclk);
    for (i = 0; i < 2; i++) begin
        sw_trap_num <= i ? 7'h05 : 7'h7f;
        sw_trap_req <= 1'h1;
        @(posedge pclk);
        sw_trap_req <= 1'h0;
        wait_for(2);
        chk(lat, 32'h1);
        chk(trap_vector, i ? 9'h014 : 9'h1fc);
        chk(trap_set_level, 32'h0);
    end
    apb(0, `ADDR_REQ_FLAGS, 32'h0);
    chk(q[2], 32'h1);
    // Hardware traps, one handler after another
    for (i = 0; i < 7; i++) begin
        segmented <= i[0];
        {nmi_evt, stk_over_evt, stk_under_evt, debug_evt, class_b_evt} <= traps[i].ev;
        @(posedge pclk);
        {nmi_evt, stk_over_evt, stk_under_evt, debug_evt, class_b_evt} <= 9'h0;
        wait_for(2);
        chk(lat, 32'h2);
        chk(trap_vector, traps[i].vec);
        chk({trap_set_level, trap_level}, 5'h1f);
        chk(trap_cancel, traps[i].cnc);
        chk(trap_cs_zero, i[0]);
        apb(0, `ADDR_TRAP_FLAGS, 32'h0);
        chk(q, traps[i].fl);
        apb(1, `ADDR_TRAP_FLAGS, 32'h0);
        repeat (14) @(posedge pclk);
    end
    // Mid-run reset
    presetn <= 1'h0;
    @(posedge pclk);
    chk(prdata, 32'h0);
    chk({trap_set_level, trap_level, trap_vector}, 32'h0);
    presetn <= 1'h1;
    apb(0, `ADDR_EDGE_SEL, 32'h0);
    chk(q, 32'h0);
    give_verdict;
end
endmodule // evt_trap_entry_tb_top
bind evt_trap_entry evt_trap_entry_assertions evt_trap_entry_assertions_inst (.pclk,
    .presetn, .psel, .penable, .paddr, .pready, .pslverr, .sleep_mode, .sleep_wake,
    .segmented, .sw_trap_req, .sw_trap_num, .xfer_inject, .xfer_done, .instr_stall,
    .irq_block, .trap_take, .trap_vector, .trap_set_level, .trap_level, .trap_cs_zero,
    .trap_cancel);
